// [ups_status_pkg.sv]
package ups_status_pkg;

  // ==========================================================
  // Clock and time base
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

  // ==========================================================
  // Times in milliseconds (counted in ticks), overload limits in seconds
  localparam int SHORT_OFF_MS = 4000;
  localparam int OFF_TOTAL_MS = 10000;
  localparam int OFF_FINAL_MS = 1000;
  localparam int BUF_MAX_MS   = 30000;
  localparam int BUF_HOT_MS   = 10000;
  localparam int MEAS_MS      = 1000;
  localparam int FLASH_MS     = 1000;
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 125;
  localparam int PRESS_MS     = 1000;
  localparam int OVL_EXT_S    = 10;
  localparam int OVL_BAT_S    = 1;

  // ==========================================================
  // Power and charge thresholds
  localparam int MAX_W        = 50;
  localparam int LOAD_YEL_PCT = 80;
  localparam int LOAD_RED_PCT = 95;
  localparam int SEG_PCT      = 25;
  localparam int LOW_PCT      = 10;
  localparam int SEGS         = 4;

  // ==========================================================
  // Register map (word addresses as byte offsets)
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MEAS   = 4'h8;
  localparam int         CTRL_OFF_BIT = 0;
  localparam int         CTRL_ON_BIT  = 1;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LED_OFF    = 3'h0,
    LED_GREEN  = 3'h1,
    LED_YELLOW = 3'h2,
    LED_RED    = 3'h3,
    LED_BLUE   = 3'h4
  } led_t;

  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_ON      = 3'h1,
    ST_STOP    = 3'h2,
    ST_FINAL   = 3'h3,
    ST_BLOCKED = 3'h4
  } pwr_state_t;

  typedef struct packed {
    logic       ext_ok;
    logic       on_battery;
    logic       fault;
    logic       off_blocked;
    logic       short_trip;
    logic       charging;
    logic       temp_hot;
    logic       temp_cold;
    logic       base_attached;
    logic       meas_running;
    logic       store_done;
    logic [7:0] power_w;
    logic [7:0] derate_w;
    logic [6:0] charge_pct;
  } cond_t;

  typedef struct packed {
    led_t             power;
    led_t             load;
    led_t [SEGS-1:0]  gauge;
  } leds_t;

endpackage

// [ups_tick_divider.sv]
`timescale 1ns/10ps
module ups_tick_divider
  import ups_status_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  // Tick out
  output logic      o_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  // ==========================================================
  // Elaboration check
  if (DIV < 1) begin : g_div_check
    $error("DIV must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;

  // Wrap counter, one-cycle pulse on wrap
  always_comb begin
    st_next      = st_reg;
    st_next.tick = (st_reg.cnt == LAST);
    st_next.cnt  = (st_reg.cnt == LAST) ? '0 : st_reg.cnt + 1'b1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

endmodule

// [ups_status_indicator.sv]
`timescale 1ns/10ps
// Behaviour
// - Power LED green on external supply
// - Power LED yellow on battery
// - Fault or blocked off: red, others dark (a fault while off leaves the power LED dark too)
// - Load green below 80 percent
// - Load yellow from 80 to 95 percent
// - Load steady red above 95 percent
// - Short: output off 4 s, red flash
// - Over derated limit: red/blue alternate flash
// - One gauge segment per 25 percent
// - Charging: rightmost lit segment flashes green
// - Below 10 percent: left segment fast flash
// - Too hot: no charge, 10 s buffer
// - Too cold: no charge, cold indication
// - Internal fault: all gauge segments dark
// - Module button switches base unit
// - Off: stop measurement, store, within 10 s
// - Latched off completes without held button
// - No measurement: off after 1 s
// - Overload over 50 W: shutdown 10 s / 1 s
// - Buffer limited to 30 s, then shutdown
module ups_status_indicator
  import ups_status_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_reset,
  // Measured conditions and button
  input  wire cond_t             i_cond,
  input  wire logic              i_button,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Indicators
  output leds_t                  o_leds,
  // Power path and base unit control
  output logic                   o_output_en,
  output logic                   o_charge_en,
  output logic                   o_base_run,
  output logic                   o_meas_stop,
  output logic                   o_hold_on
);

  // ==========================================================
  // Scaled thresholds
  localparam logic [15:0] YEL_LIM = 16'(MAX_W * LOAD_YEL_PCT);
  localparam logic [15:0] RED_LIM = 16'(MAX_W * LOAD_RED_PCT);
  localparam logic [14:0] STOP_MAX = 15'(OFF_TOTAL_MS - OFF_FINAL_MS);

  typedef struct packed {
    pwr_state_t  pst;
    logic [14:0] st_ms;
    logic [12:0] short_ms;
    logic [14:0] buf_ms;
    logic [9:0]  phase_ms;
    logic [9:0]  meas_ms;
    logic [9:0]  press_ms;
    logic        press_done;
    logic [7:0]  power_w;
    logic [3:0]  ovl_s;
    logic        ack;
    logic [31:0] rdata;
    leds_t       leds;
    logic        out_en;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic   tick;

  // ==========================================================
  // Millisecond time base
  ups_tick_divider #(
    .DIV (TICK_DIV)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .o_tick    (tick)
  );

  // Output power scaled to percent of maximum times MAX_W
  function automatic logic [15:0] pct_scaled(input logic [7:0] w);
    pct_scaled = 16'(w) * 16'h64;
  endfunction

  // Segment i lit when charge is above i quarters
  function automatic logic seg_lit(input logic [6:0] pct, input int i);
    seg_lit = (8'(pct) > 8'(i * SEG_PCT));
  endfunction

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic        slow_on;
    logic        fast_on;
    logic        req_on;
    logic        req_off;
    logic        buf_lim;
    logic        derate;
    logic        lit;
    logic        wr_ok;
    logic [3:0]  ovl_lim;
    logic [2:0]  top_seg;
    slow_on = 1'b0;
    fast_on = 1'b0;
    req_on  = 1'b0;
    req_off = 1'b0;
    buf_lim = 1'b0;
    derate  = 1'b0;
    lit     = 1'b0;
    wr_ok   = 1'b0;
    ovl_lim = 4'(OVL_EXT_S);
    top_seg = '0;
    st_next = st_reg;

    // Bus: one wait cycle, then answer; write lands on the answering edge
    st_next.ack = (i_avs_read | i_avs_write) & ~st_reg.ack;
    wr_ok       = i_avs_write & st_reg.ack & (i_avs_address == REG_CTRL);
    if (!st_reg.ack) begin
      unique case (i_avs_address)
        REG_CTRL:   st_next.rdata = '0;
        REG_STATUS: st_next.rdata = {13'h0, st_reg.pst, st_reg.ovl_s, st_reg.out_en,
                                     i_cond.fault, i_cond.on_battery, i_cond.ext_ok,
                                     st_reg.buf_ms[14:7]};
        REG_MEAS:   st_next.rdata = {9'h0, i_cond.charge_pct, 8'h0, st_reg.power_w};
        default:    st_next.rdata = '0;
      endcase
    end

    // Flash phase, 1 s period
    if (tick) begin
      st_next.phase_ms = (st_reg.phase_ms == 10'(FLASH_MS - 1)) ? '0 : st_reg.phase_ms + 1'b1;
    end
    slow_on = (st_reg.phase_ms < 10'(SLOW_HALF_MS));
    fast_on = (st_reg.phase_ms[7:0] < 8'(FAST_HALF_MS)) ^ st_reg.phase_ms[8];

    // Button held about 1 s gives one request; release rearms
    if (!i_button) begin
      st_next.press_ms   = '0;
      st_next.press_done = 1'b0;
    end else if (tick && !st_reg.press_done) begin
      st_next.press_ms = st_reg.press_ms + 1'b1;
      if (st_reg.press_ms == 10'(PRESS_MS - 1)) begin
        st_next.press_done = 1'b1;
      end
    end
    req_on  = (tick && i_button && !st_reg.press_done && st_reg.press_ms == 10'(PRESS_MS - 1))
              || (wr_ok && i_avs_writedata[CTRL_ON_BIT]);
    req_off = req_on || (wr_ok && i_avs_writedata[CTRL_OFF_BIT]);

    // Output power sampled once per second, overload seconds counted
    if (tick) begin
      st_next.meas_ms = (st_reg.meas_ms == 10'(MEAS_MS - 1)) ? '0 : st_reg.meas_ms + 1'b1;
    end
    ovl_lim = i_cond.on_battery ? 4'(OVL_BAT_S) : 4'(OVL_EXT_S);
    if (st_reg.pst != ST_ON) begin
      st_next.ovl_s = '0;
    end else if (tick && st_reg.meas_ms == 10'(MEAS_MS - 1)) begin
      st_next.power_w = i_cond.power_w;
      if (i_cond.power_w > 8'(MAX_W)) begin
        st_next.ovl_s = (st_reg.ovl_s == ovl_lim) ? st_reg.ovl_s : st_reg.ovl_s + 1'b1;
      end else begin
        st_next.ovl_s = '0;
      end
    end

    // Buffer time, shortened when the battery is hot
    if (!i_cond.on_battery || st_reg.pst != ST_ON) begin
      st_next.buf_ms = '0;
    end else if (tick) begin
      st_next.buf_ms = st_reg.buf_ms + 1'b1;
    end
    buf_lim = i_cond.temp_hot ? (st_reg.buf_ms >= 15'(BUF_HOT_MS))
                              : (st_reg.buf_ms >= 15'(BUF_MAX_MS));

    // Short-circuit lockout of the output
    if (st_reg.short_ms != '0) begin
      if (tick) begin
        st_next.short_ms = st_reg.short_ms - 1'b1;
      end
    end else if (i_cond.short_trip && st_reg.pst == ST_ON) begin
      st_next.short_ms = 13'(SHORT_OFF_MS);
    end

    // Power sequencing
    if (tick && st_reg.st_ms != 15'h7fff) begin
      st_next.st_ms = st_reg.st_ms + 1'b1;
    end
    unique case (st_reg.pst)
      ST_OFF: begin
        if (req_on && i_cond.ext_ok) begin
          st_next.pst   = ST_ON;
          st_next.st_ms = '0;
        end
      end
      ST_ON: begin
        if (req_off || buf_lim || (st_reg.ovl_s == ovl_lim && ovl_lim != '0)
            || (i_cond.on_battery && i_cond.charge_pct == '0)) begin
          st_next.pst   = i_cond.meas_running ? ST_STOP : ST_FINAL;
          st_next.st_ms = '0;
        end
      end
      ST_STOP: begin
        if (i_cond.store_done || st_reg.st_ms >= STOP_MAX) begin
          st_next.pst   = ST_FINAL;
          st_next.st_ms = '0;
        end
      end
      ST_FINAL: begin
        if (st_reg.st_ms >= 15'(OFF_FINAL_MS)) begin
          st_next.pst = i_cond.off_blocked ? ST_BLOCKED : ST_OFF;
        end
      end
      ST_BLOCKED: begin
        if (!i_cond.off_blocked) begin
          st_next.pst = ST_OFF;
        end
      end
      default: st_next.pst = ST_OFF;
    endcase
    st_next.out_en = (st_next.pst != ST_OFF) && (st_next.pst != ST_BLOCKED)
                     && (st_next.short_ms == '0);

    // Power LED
    derate = (st_reg.power_w > i_cond.derate_w);
    if (st_reg.pst == ST_OFF) begin
      st_next.leds.power = LED_OFF;
    end else if (i_cond.fault || st_reg.pst == ST_BLOCKED) begin
      st_next.leds.power = LED_RED;
    end else if (i_cond.on_battery) begin
      st_next.leds.power = LED_YELLOW;
    end else if (i_cond.ext_ok) begin
      st_next.leds.power = LED_GREEN;
    end else begin
      st_next.leds.power = LED_OFF;
    end

    // Load LED, fault first, then short, derate, thresholds
    if (st_reg.pst == ST_OFF || st_reg.pst == ST_BLOCKED || i_cond.fault) begin
      st_next.leds.load = LED_OFF;
    end else if (st_reg.short_ms != '0) begin
      st_next.leds.load = slow_on ? LED_RED : LED_OFF;
    end else if (derate) begin
      st_next.leds.load = slow_on ? LED_RED : LED_BLUE;
    end else if (pct_scaled(st_reg.power_w) > RED_LIM) begin
      st_next.leds.load = LED_RED;
    end else if (pct_scaled(st_reg.power_w) >= YEL_LIM) begin
      st_next.leds.load = LED_YELLOW;
    end else begin
      st_next.leds.load = LED_GREEN;
    end

    // Gauge: temperature colours replace green, fault darkens it
    top_seg = '0;
    for (int i = 0; i < SEGS; i++) begin
      if (seg_lit(i_cond.charge_pct, i)) begin
        top_seg = 3'(i + 1);
      end
    end
    for (int i = 0; i < SEGS; i++) begin
      lit = seg_lit(i_cond.charge_pct, i);
      if (st_reg.pst == ST_OFF || st_reg.pst == ST_BLOCKED || i_cond.fault) begin
        st_next.leds.gauge[i] = LED_OFF;
      end else if (i_cond.charge_pct < 7'(LOW_PCT)) begin
        st_next.leds.gauge[i] = (i == 0 && fast_on) ? LED_RED : LED_OFF;
      end else if (!lit) begin
        st_next.leds.gauge[i] = LED_OFF;
      end else if (i_cond.temp_hot) begin
        st_next.leds.gauge[i] = LED_RED;
      end else if (i_cond.temp_cold) begin
        st_next.leds.gauge[i] = LED_BLUE;
      end else if (i_cond.charging && 3'(i + 1) == top_seg) begin
        st_next.leds.gauge[i] = slow_on ? LED_GREEN : LED_OFF;
      end else begin
        st_next.leds.gauge[i] = LED_GREEN;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; charge enable is a gate, held off when too hot or cold
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_reg.ack;
  assign o_avs_readdata    = st_reg.rdata;
  assign o_leds            = st_reg.leds;
  assign o_output_en       = st_reg.out_en;
  assign o_charge_en       = ~(i_cond.temp_hot | i_cond.temp_cold | i_cond.fault);
  assign o_base_run        = (st_reg.pst == ST_ON) || (st_reg.pst == ST_STOP);
  assign o_meas_stop       = (st_reg.pst == ST_STOP);
  assign o_hold_on         = (st_reg.pst != ST_OFF);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
                              ##1 (i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  fault_red_a: assert property (i_cond.fault && st_reg.pst != ST_OFF |=> o_leds.power == LED_RED
                               && o_leds.load == LED_OFF && o_leds.gauge == '0)
    else $error("fault did not show red with others dark");
  batt_yel_a: assert property (st_reg.pst == ST_ON && !i_cond.fault && i_cond.on_battery
                              |=> o_leds.power == LED_YELLOW)
    else $error("battery mode not yellow");
  short_off_a: assert property (st_reg.short_ms != '0 |-> !o_output_en)
    else $error("output on during short lockout");
  short_start_a: assert property (st_reg.pst == ST_ON && st_reg.short_ms == '0 && i_cond.short_trip
                                 |=> st_reg.short_ms == 13'(SHORT_OFF_MS))
    else $error("short lockout not loaded with 4 s");
  stop_bound_a: assert property (st_reg.pst == ST_STOP |-> st_reg.st_ms <= STOP_MAX)
    else $error("stop phase exceeded its share of 10 s");
  final_len_a: assert property (st_reg.pst == ST_FINAL && st_reg.st_ms >= 15'(OFF_FINAL_MS)
                               |=> st_reg.pst inside {ST_OFF, ST_BLOCKED})
    else $error("final phase did not end after 1 s");
  buf_hot_a: assert property (st_reg.pst == ST_ON && i_cond.temp_hot
                             && st_reg.buf_ms >= 15'(BUF_HOT_MS) |=> st_reg.pst != ST_ON)
    else $error("hot buffer ran past 10 s");
  buf_max_a: assert property (st_reg.pst == ST_ON && st_reg.buf_ms >= 15'(BUF_MAX_MS)
                             |=> st_reg.pst != ST_ON)
    else $error("buffer ran past 30 s");
  no_charge_a: assert property (i_cond.temp_hot || i_cond.temp_cold |-> !o_charge_en)
    else $error("charging while out of temperature");
  low_seg_a: assert property (st_reg.pst == ST_ON && !i_cond.fault && i_cond.charge_pct < 7'(LOW_PCT)
                             |=> o_leds.gauge[3:1] == '0)
    else $error("low charge lit more than left segment");

  cov_short_c: cover property (st_reg.short_ms == 13'(SHORT_OFF_MS));
  cov_stop_c:  cover property (st_reg.pst == ST_STOP ##1 st_reg.pst == ST_FINAL);
  cov_block_c: cover property (st_reg.pst == ST_BLOCKED);
  cov_derate_c: cover property (o_leds.load == LED_BLUE);

endmodule

// [testbench.sv]
`timescale 1ns/10ps
module testbench
  import ups_status_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  localparam int DIV = 1;
  logic              ref_clk;
  logic              reset;
  cond_t             cond;
  logic              btn;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              wait_req;
  leds_t             leds;
  logic              out_en;
  logic              chg_en;
  logic              base_run;
  logic              meas_stop;
  logic              hold_on;
  logic [31:0]       d;
  logic [7:0]        m;
  int                fails;
  int                cmp_count;
  int                cycles;

  // One tick per cycle, so that 30 s of buffer fit the run
  ups_status_indicator #(.TICK_DIV(DIV)) dut_u (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_cond(cond), .i_button(btn),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_leds(leds),
    .o_output_en(out_en), .o_charge_en(chg_en), .o_base_run(base_run),
    .o_meas_stop(meas_stop), .o_hold_on(hold_on)
  );

  // ==========================================================
  // Clock and hang guard
  always #20 ref_clk = ~ref_clk;

  // Ceiling well above the roughly 86k cycles of the sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 95000) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Settle point is the falling edge, clear of register updates
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Request held until waitrequest is sampled low at a rising edge; only the hang guard ends a wait
  task automatic bus(input logic is_rd, input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    rd    <= is_rd;
    wr    <= ~is_rd;
    addr  <= a;
    wdata <= v;
    do begin
      @(posedge ref_clk);
    end while (wait_req !== 1'b0);
    d = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic press(input int n);
    @(posedge ref_clk);
    btn <= 1'b1;
    repeat (n) @(posedge ref_clk);
    btn <= 1'b0;
  endtask

  // Collects which colours a lamp shows; sel below zero is the load lamp
  task automatic watch(input int sel, input int n);
    led_t v;
    m = 8'h00;
    repeat (n) begin
      @(negedge ref_clk);
      v = (sel < 0) ? leds.load : leds.gauge[sel];
      m[v] = 1'b1;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    cond = '0;
    cond.charge_pct = 7'h4b;
    cond.derate_w = 8'h64;
    cond.power_w = 8'h0a;
    btn = 1'b0;
    addr = '0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = '0;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    cond.ext_ok <= 1'b1;
    w(2);
    check(leds.power, LED_OFF);
    check(hold_on, 1'b0);
    // Register access, unmapped place included
    bus(1'b0, 4'hc, 32'hffff_ffff);
    bus(1'b1, 4'hc, 32'h0);
    check(d, 32'h0);
    bus(1'b1, REG_CTRL, 32'h0);
    check(d, 32'h0);
    bus(1'b1, REG_STATUS, 32'h0);
    check(d[18:16], ST_OFF);
    check(d[8], 1'b1);
    // Module button switches the base unit on
    press(1100);
    w(4);
    check(hold_on, 1'b1);
    check(base_run, 1'b1);
    check(leds.power, LED_GREEN);
    bus(1'b1, REG_MEAS, 32'h0);
    check(d[22:16], 7'h4b);
    // Gauge at 75 percent: three segments, fourth on the boundary stays dark
    check(leds.gauge[2], LED_GREEN);
    check(leds.gauge[3], LED_OFF);
    @(posedge ref_clk);
    cond.charging <= 1'b1;
    watch(2, 1250);
    check(m, 8'h03);
    check(leds.gauge[1], LED_GREEN);
    check(chg_en, 1'b1);
    @(posedge ref_clk);
    cond.charging <= 1'b0;
    // Load thresholds on the sampled power: 60, 80, 94 and 96 percent of 50 W
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      cond.power_w <= (i == 0) ? 8'h1e : (i == 1) ? 8'h28 : (i == 2) ? 8'h2f : 8'h30;
      w(1100);
      check(leds.load, (i == 0) ? LED_GREEN : (i == 3) ? LED_RED : LED_YELLOW);
    end
    // Above derated limit
    @(posedge ref_clk);
    cond.power_w <= 8'h1e;
    cond.derate_w <= 8'h14;
    w(1100);
    watch(-1, 1250);
    check(m, 8'h18);
    // Short during derating: short flash wins, output off for 4 s
    @(posedge ref_clk);
    cond.short_trip <= 1'b1;
    @(posedge ref_clk);
    cond.short_trip <= 1'b0;
    w(10);
    check(out_en, 1'b0);
    watch(-1, 1250);
    check(m, 8'h09);
    w(2500);
    check(out_en, 1'b0);
    w(350);
    check(out_en, 1'b1);
    @(posedge ref_clk);
    cond.derate_w <= 8'h64;
    // Battery operation and deep discharge
    cond.ext_ok <= 1'b0;
    cond.on_battery <= 1'b1;
    cond.charge_pct <= 7'h05;
    w(10);
    check(leds.power, LED_YELLOW);
    check(leds.gauge[1], LED_OFF);
    watch(0, 500);
    check(m, 8'h09);
    @(posedge ref_clk);
    cond.ext_ok <= 1'b1;
    cond.on_battery <= 1'b0;
    cond.charge_pct <= 7'h4b;
    cond.temp_hot <= 1'b1;
    w(10);
    check(chg_en, 1'b0);
    check(leds.gauge[0], LED_RED);
    @(posedge ref_clk);
    cond.temp_hot <= 1'b0;
    cond.temp_cold <= 1'b1;
    w(10);
    check(chg_en, 1'b0);
    check(leds.gauge[0], LED_BLUE);
    @(posedge ref_clk);
    cond.temp_cold <= 1'b0;
    cond.fault <= 1'b1;
    w(10);
    check(leds.power, LED_RED);
    check(leds.load, LED_OFF);
    check(leds.gauge, '0);
    @(posedge ref_clk);
    cond.fault <= 1'b0;
    // Off request during a measurement
    cond.meas_running <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h1);
    w(10);
    check(meas_stop, 1'b1);
    w(500);
    check(meas_stop, 1'b1);
    @(posedge ref_clk);
    cond.store_done <= 1'b1;
    w(10);
    check(meas_stop, 1'b0);
    check(hold_on, 1'b1);
    w(1100);
    check(hold_on, 1'b0);
    @(posedge ref_clk);
    cond.meas_running <= 1'b0;
    cond.store_done <= 1'b0;
    cond.off_blocked <= 1'b1;
    // On by register, off by button with the remote switch closed
    bus(1'b0, REG_CTRL, 32'h2);
    w(10);
    check(hold_on, 1'b1);
    press(1100);
    w(750);
    check(hold_on, 1'b1);
    check(base_run, 1'b0);
    w(300);
    check(leds.power, LED_RED);
    check(leds.load, LED_OFF);
    @(posedge ref_clk);
    cond.off_blocked <= 1'b0;
    w(10);
    check(hold_on, 1'b0);
    // Overload in buffer mode ends the run after one sample
    bus(1'b0, REG_CTRL, 32'h2);
    w(10);
    check(base_run, 1'b1);
    @(posedge ref_clk);
    cond.ext_ok <= 1'b0;
    cond.on_battery <= 1'b1;
    cond.power_w <= 8'h3c;
    w(1100);
    check(base_run, 1'b0);
    // Sustained overload on the external supply needs ten samples
    w(1100);
    @(posedge ref_clk);
    cond.ext_ok <= 1'b1;
    cond.on_battery <= 1'b0;
    bus(1'b0, REG_CTRL, 32'h2);
    w(9000);
    check(base_run, 1'b1);
    w(2000);
    check(base_run, 1'b0);
    // Buffer limits: 10 s while hot, then 30 s at normal temperature
    w(1100);
    @(posedge ref_clk);
    cond.power_w <= 8'h0a;
    cond.temp_hot <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, REG_CTRL, 32'h2);
      @(posedge ref_clk);
      cond.ext_ok <= 1'b0;
      cond.on_battery <= 1'b1;
      w((i == 0) ? 9500 : 29500);
      check(base_run, 1'b1);
      w(600);
      check(base_run, 1'b0);
      @(posedge ref_clk);
      cond.ext_ok <= 1'b1;
      cond.on_battery <= 1'b0;
      cond.temp_hot <= 1'b0;
      w(1100);
    end
    // Empty battery in buffer mode ends the run at once
    bus(1'b0, REG_CTRL, 32'h2);
    @(posedge ref_clk);
    cond.ext_ok <= 1'b0;
    cond.on_battery <= 1'b1;
    cond.charge_pct <= 7'h00;
    w(10);
    check(base_run, 1'b0);
    // Store never reported: forced end, whole shutdown within 10 s
    @(posedge ref_clk);
    cond.ext_ok <= 1'b1;
    cond.on_battery <= 1'b0;
    cond.charge_pct <= 7'h4b;
    cond.meas_running <= 1'b1;
    w(1100);
    bus(1'b0, REG_CTRL, 32'h2);
    bus(1'b0, REG_CTRL, 32'h1);
    w(8900);
    check(meas_stop, 1'b1);
    w(1110);
    check(hold_on, 1'b0);
    report_and_stop();
  end
endmodule
